// ---- common/nibble_core_pkg.sv ----
// constants and state layout for the nibble core move, bit and jump unit
package nibble_core_pkg;

    localparam int ROM_ADDR_W   = 10;
    localparam int PAGE_ADDR_W  = 6;
    localparam int BANK_W       = 4;
    localparam int RAM_ADDR_W   = 6;
    localparam int NIBBLE_W     = 4;
    localparam int X_W          = 2;

    // format I opcodes, all eight bits
    localparam logic [7:0] OP_COPY_Y_INTO_ACC      = 8'h00;
    localparam logic [7:0] OP_COPY_ACC_INTO_Y      = 8'h01;
    localparam logic [7:0] OP_ZERO_ACCUMULATOR     = 8'h02;
    localparam logic [7:0] OP_STORE_ACC_TO_RAM     = 8'h03;
    localparam logic [7:0] OP_STORE_ACC_ADVANCE    = 8'h04;
    localparam logic [7:0] OP_LOAD_INDEX_FROM_RAM  = 8'h05;
    localparam logic [7:0] OP_LOAD_ACC_FROM_RAM    = 8'h06;
    localparam logic [7:0] OP_SWAP_ACC_WITH_RAM    = 8'h07;

    // format II: upper six bits, operand in bits 1:0
    localparam logic [5:0] OP2_SELECT_RAM_BANK     = 6'h04;
    localparam logic [5:0] OP2_SET_RAM_BIT         = 6'h05;
    localparam logic [5:0] OP2_CLEAR_RAM_BIT       = 6'h06;
    localparam logic [5:0] OP2_TEST_MEMORY_BIT     = 6'h07;

    // format III: upper nibble, operand in bits 3:0
    localparam logic [3:0] OP3_LOAD_INDEX_IMM      = 4'h4;
    localparam logic [3:0] OP3_STORE_IMM_ADVANCE   = 4'h5;
    localparam logic [3:0] OP3_LOAD_BANK_BUFFER    = 4'h6;

    // format IV: upper two bits, page word address in bits 5:0
    localparam logic [1:0] OP4_CONDITIONAL_JUMP    = 2'h3;

    // reset values
    localparam logic [3:0] RST_ACC   = 4'h0;
    localparam logic [3:0] RST_Y     = 4'h0;
    localparam logic [1:0] RST_X     = 2'h0;
    localparam logic       RST_FLAG  = 1'b1;
    localparam logic [5:0] RST_PC    = 6'h00;
    localparam logic [3:0] RST_BANK  = 4'h0;
    localparam logic [7:0] RST_INSTR = 8'h00;

    typedef enum logic [1:0]
    {
        PH_FETCH = 2'b00,
        PH_READ  = 2'b01,
        PH_EXEC  = 2'b10
    } phase_e;

    typedef struct packed
    {
        phase_e     phase;
        logic [7:0] instr;
        logic [3:0] acc;
        logic [3:0] indexY;
        logic [1:0] bankX;
        logic       conditionFlag;
        logic [5:0] programCounter;
        logic [3:0] currentCodeBank;
        logic [3:0] pendingCodeBank;
        logic [5:0] ramAddr;
        logic       ramWrEn;
        logic [3:0] ramWrData;
        logic       retire;
    } core_s;

endpackage

// ---- src/nibble_core_move_bit_branch_ops.sv ----
// execution unit for moves, ram bit operations and conditional jumps of a nibble core
// Summary of operation
// - copy Y into accumulator, Y kept, flag set.
// - copy accumulator into Y, flag set.
// - clear accumulator to zero, flag set.
// - write accumulator to RAM at X,Y, accumulator kept, flag set.
// - write accumulator to RAM at X,Y, then Y plus one, flag set.
// - load RAM word at X,Y into Y, memory kept, flag set.
// - load RAM word at X,Y into accumulator, memory kept, flag set.
// - swap accumulator with RAM word at X,Y, flag set.
// - load four-bit immediate into Y, flag set.
// - write immediate to RAM at X,Y, then Y plus one, flag set.
// - load two-bit operand into X to pick RAM page, flag set.
// - set selected bit of RAM word at X,Y, others kept.
// - clear selected bit of RAM word at X,Y, others kept.
// - flag takes the selected bit of RAM word at X,Y.
// - flag one: jump copies pending bank to current bank, loads PC.
// - flag zero: jump falls through to next PC, flag set.
// - program counter steps along a fixed pseudo-random sequence.
// - jumps stay in page unless pending bank was loaded first.
// - unconditional-status instructions set the flag each execution.
// - jump carries a six-bit word address within a page.
// - immediate format carries a four-bit constant or page number.
// - bank buffer immediate loads the pending code bank.
`timescale 1ns/100ps
`default_nettype none

module nibble_core_move_bit_branch_ops
    import nibble_core_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    output logic      [ROM_ADDR_W-1:0] romAddr,
    input  wire logic [7:0]            romData,
    output logic      [RAM_ADDR_W-1:0] ramAddr,
    input  wire logic [NIBBLE_W-1:0]   ramRdData,
    output logic                       ramWrEn,
    output logic      [NIBBLE_W-1:0]   ramWrData,
    output logic      [NIBBLE_W-1:0]   accumulator,
    output logic      [NIBBLE_W-1:0]   indexY,
    output logic      [X_W-1:0]        bankX,
    output logic                       conditionFlag,
    output logic      [BANK_W-1:0]     currentCodeBank,
    output logic      [BANK_W-1:0]     pendingCodeBank,
    output logic                       retire
);

    core_s cur;
    core_s next_cur;

    logic [5:0] seqPc;
    logic [3:0] bitMask;
    logic [3:0] nextY;

    // xnor feedback keeps the all-zero reset value on the cycle
    assign seqPc   = {cur.programCounter[4:0], ~(cur.programCounter[5] ^ cur.programCounter[4])};
    assign bitMask = 4'h1 << cur.instr[1:0];
    assign nextY   = cur.indexY + 4'h1;

    always_comb
    begin
        next_cur         = cur;
        next_cur.ramWrEn = 1'b0;
        next_cur.retire  = 1'b0;
        case (cur.phase)
            PH_FETCH:
            begin
                // write of the previous instruction lands at the old address this cycle
                next_cur.ramAddr = {cur.bankX, cur.indexY};
                next_cur.phase   = PH_READ;
            end
            PH_READ:
            begin
                next_cur.instr = romData;
                next_cur.phase = PH_EXEC;
            end
            PH_EXEC:
            begin
                next_cur.phase          = PH_FETCH;
                next_cur.retire         = 1'b1;
                next_cur.programCounter = seqPc;
                next_cur.ramWrData      = cur.ramWrData;
                if (cur.instr[7:6] == OP4_CONDITIONAL_JUMP)
                begin
                    if (cur.conditionFlag)
                    begin
                        next_cur.currentCodeBank = cur.pendingCodeBank;
                        next_cur.programCounter  = cur.instr[5:0];
                    end
                    else
                    begin
                        next_cur.conditionFlag = 1'b1;
                    end
                end
                else if (cur.instr[7:4] == OP3_LOAD_INDEX_IMM)
                begin
                    next_cur.indexY        = cur.instr[3:0];
                    next_cur.conditionFlag = 1'b1;
                end
                else if (cur.instr[7:4] == OP3_STORE_IMM_ADVANCE)
                begin
                    next_cur.ramWrEn       = 1'b1;
                    next_cur.ramWrData     = cur.instr[3:0];
                    next_cur.indexY        = nextY;
                    next_cur.conditionFlag = 1'b1;
                end
                else if (cur.instr[7:4] == OP3_LOAD_BANK_BUFFER)
                begin
                    next_cur.pendingCodeBank = cur.instr[3:0];
                    next_cur.conditionFlag   = 1'b1;
                end
                else
                begin
                    case (cur.instr[7:2])
                        OP2_SELECT_RAM_BANK:
                        begin
                            next_cur.bankX         = cur.instr[1:0];
                            next_cur.conditionFlag = 1'b1;
                        end
                        OP2_SET_RAM_BIT:
                        begin
                            next_cur.ramWrEn       = 1'b1;
                            next_cur.ramWrData     = ramRdData | bitMask;
                            next_cur.conditionFlag = 1'b1;
                        end
                        OP2_CLEAR_RAM_BIT:
                        begin
                            next_cur.ramWrEn       = 1'b1;
                            next_cur.ramWrData     = ramRdData & ~bitMask;
                            next_cur.conditionFlag = 1'b1;
                        end
                        OP2_TEST_MEMORY_BIT:
                        begin
                            next_cur.conditionFlag = |(ramRdData & bitMask);
                        end
                        default:
                        begin
                            case (cur.instr)
                                OP_COPY_Y_INTO_ACC:
                                begin
                                    next_cur.acc           = cur.indexY;
                                    next_cur.conditionFlag = 1'b1;
                                end
                                OP_COPY_ACC_INTO_Y:
                                begin
                                    next_cur.indexY        = cur.acc;
                                    next_cur.conditionFlag = 1'b1;
                                end
                                OP_ZERO_ACCUMULATOR:
                                begin
                                    next_cur.acc           = 4'h0;
                                    next_cur.conditionFlag = 1'b1;
                                end
                                OP_STORE_ACC_TO_RAM:
                                begin
                                    next_cur.ramWrEn       = 1'b1;
                                    next_cur.ramWrData     = cur.acc;
                                    next_cur.conditionFlag = 1'b1;
                                end
                                OP_STORE_ACC_ADVANCE:
                                begin
                                    next_cur.ramWrEn       = 1'b1;
                                    next_cur.ramWrData     = cur.acc;
                                    next_cur.indexY        = nextY;
                                    next_cur.conditionFlag = 1'b1;
                                end
                                OP_LOAD_INDEX_FROM_RAM:
                                begin
                                    next_cur.indexY        = ramRdData;
                                    next_cur.conditionFlag = 1'b1;
                                end
                                OP_LOAD_ACC_FROM_RAM:
                                begin
                                    next_cur.acc           = ramRdData;
                                    next_cur.conditionFlag = 1'b1;
                                end
                                OP_SWAP_ACC_WITH_RAM:
                                begin
                                    next_cur.acc           = ramRdData;
                                    next_cur.ramWrEn       = 1'b1;
                                    next_cur.ramWrData     = cur.acc;
                                    next_cur.conditionFlag = 1'b1;
                                end
                                default:
                                begin
                                    // opcodes of other units: only the counter moves here
                                    next_cur.conditionFlag = cur.conditionFlag;
                                end
                            endcase
                        end
                    endcase
                end
            end
            default:
            begin
                next_cur.phase = PH_FETCH;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur.phase           <= PH_FETCH;
            cur.instr           <= RST_INSTR;
            cur.acc             <= RST_ACC;
            cur.indexY          <= RST_Y;
            cur.bankX           <= RST_X;
            cur.conditionFlag   <= RST_FLAG;
            cur.programCounter  <= RST_PC;
            cur.currentCodeBank <= RST_BANK;
            cur.pendingCodeBank <= RST_BANK;
            cur.ramAddr         <= {RST_X, RST_Y};
            cur.ramWrEn         <= 1'b0;
            cur.ramWrData       <= RST_ACC;
            cur.retire          <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign romAddr         = {cur.currentCodeBank, cur.programCounter};
    assign ramAddr         = cur.ramAddr;
    assign ramWrEn         = cur.ramWrEn;
    assign ramWrData       = cur.ramWrData;
    assign accumulator     = cur.acc;
    assign indexY          = cur.indexY;
    assign bankX           = cur.bankX;
    assign conditionFlag   = cur.conditionFlag;
    assign currentCodeBank = cur.currentCodeBank;
    assign pendingCodeBank = cur.pendingCodeBank;
    assign retire          = cur.retire;

endmodule

`default_nettype wire

// ---- tb/nibble_core_rom_ram.sv ----
// behavioural program rom and nibble ram facing the core
`timescale 1ns/100ps
`default_nettype none
module nibble_core_rom_ram
    import nibble_core_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic [ROM_ADDR_W-1:0] romAddr,
    output logic      [7:0]            romData,
    input  wire logic [RAM_ADDR_W-1:0] ramAddr,
    output logic      [NIBBLE_W-1:0]   ramRdData,
    input  wire logic                  ramWrEn,
    input  wire logic [NIBBLE_W-1:0]   ramWrData
);
    logic [7:0]          rom [1024];
    logic [NIBBLE_W-1:0] ram [64];
    // unwritten words hold an unlisted opcode, which only steps the pc
    initial
    begin
        for (int i = 0; i < 1024; i++)
            rom[i] = 8'h08;
        for (int i = 0; i < 64; i++)
            ram[i] = i[3:0] ^ 4'h5;
    end
    always @(posedge clk)
    begin
        romData   <= rom[romAddr];
        ramRdData <= ram[ramAddr];
        if (ramWrEn)
            ram[ramAddr] <= ramWrData;
    end
endmodule
`default_nettype wire

// ---- tb/nibble_core_move_bit_branch_ops_sva.sv ----
// assertion checker for the nibble core move, bit and jump unit
`timescale 1ns/100ps
`default_nettype none
module nibble_core_move_bit_branch_ops_sva
    import nibble_core_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic [ROM_ADDR_W-1:0] romAddr,
    input wire logic [7:0]            romData,
    input wire logic [RAM_ADDR_W-1:0] ramAddr,
    input wire logic                  ramWrEn,
    input wire logic [NIBBLE_W-1:0]   ramWrData,
    input wire logic [NIBBLE_W-1:0]   accumulator,
    input wire logic [NIBBLE_W-1:0]   indexY,
    input wire logic [X_W-1:0]        bankX,
    input wire logic                  conditionFlag,
    input wire logic [BANK_W-1:0]     currentCodeBank,
    input wire logic [BANK_W-1:0]     pendingCodeBank,
    input wire logic                  retire
);
    logic [1:0] ph;
    // phase mirror, so opcode-driven checks know when romData holds the instruction
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            ph <= 2'h0;
        else
            ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    wire logic rd = (ph == 2'h1);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_retire_spacing: assert property (retire |=> !retire [*2])
        else $error("retire closer than three cycles");
    a_write_in_fetch: assert property (ramWrEn |-> retire)
        else $error("ram write outside fetch cycle");
    a_rom_addr_hold: assert property (!$stable(romAddr) |-> retire)
        else $error("romAddr moved mid instruction");
    a_state_at_retire: assert property
        (!$stable({accumulator, indexY, bankX, conditionFlag, pendingCodeBank}) |-> retire)
        else $error("core state moved mid instruction");
    a_ram_addr_xy: assert property (rd |-> ramAddr == {bankX, indexY})
        else $error("ramAddr not X,Y");
    a_bank_copy: assert property
        (!$stable(currentCodeBank) |-> currentCodeBank == $past(pendingCodeBank))
        else $error("current bank not taken from pending bank");
    a_zero_acc: assert property
        (rd && romData == OP_ZERO_ACCUMULATOR |-> ##2 accumulator == 4'h0 && conditionFlag)
        else $error("accumulator not cleared");
    a_jump_taken: assert property
        (rd && romData[7:6] == OP4_CONDITIONAL_JUMP && conditionFlag
         |-> ##2 romAddr == {pendingCodeBank, $past(romData[5:0], 2)})
        else $error("taken jump target wrong");
    a_jump_fall: assert property
        (rd && romData[7:6] == OP4_CONDITIONAL_JUMP && !conditionFlag |-> ##2 conditionFlag)
        else $error("untaken jump left flag low");
    a_store_acc: assert property
        (rd && romData == OP_STORE_ACC_TO_RAM |-> ##2 ramWrEn && ramWrData == accumulator)
        else $error("store did not write accumulator");
endmodule
bind nibble_core_move_bit_branch_ops nibble_core_move_bit_branch_ops_sva u_sva
    (.clk(clk), .rst_b(rst_b), .romAddr(romAddr), .romData(romData), .ramAddr(ramAddr),
     .ramWrEn(ramWrEn), .ramWrData(ramWrData), .accumulator(accumulator), .indexY(indexY),
     .bankX(bankX), .conditionFlag(conditionFlag), .currentCodeBank(currentCodeBank),
     .pendingCodeBank(pendingCodeBank), .retire(retire));
`default_nettype wire

// ---- tb/nibble_core_move_bit_branch_ops_tb.sv ----
// self-checking bench for the nibble core move, bit and jump unit
`timescale 1ns/100ps
`default_nettype none
module nibble_core_move_bit_branch_ops_tb
    import nibble_core_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, ramWrEn, conditionFlag, retire, eFlag = 1'b1;
    logic [9:0] romAddr;
    logic [7:0] romData;
    logic [5:0] ramAddr, ePc = 6'h00;
    logic [3:0] ramRdData, ramWrData, accumulator, indexY, currentCodeBank, pendingCodeBank;
    logic [3:0] eAcc = 4'h0, eY = 4'h0, eCb = 4'h0, ePend = 4'h0;
    logic [3:0] eRam [64];
    logic [1:0] bankX, eX = 2'h0;
    int errors = 0, checks_done = 0, cycles = 0;
    always #2 clk = ~clk;
    nibble_core_move_bit_branch_ops u_nibble_core_move_bit_branch_ops
        (.clk(clk), .rst_b(rst_b), .romAddr(romAddr), .romData(romData), .ramAddr(ramAddr),
         .ramRdData(ramRdData), .ramWrEn(ramWrEn), .ramWrData(ramWrData),
         .accumulator(accumulator), .indexY(indexY), .bankX(bankX), .conditionFlag(conditionFlag),
         .currentCodeBank(currentCodeBank), .pendingCodeBank(pendingCodeBank), .retire(retire));
    nibble_core_rom_ram u_nibble_core_rom_ram
        (.clk(clk), .romAddr(romAddr), .romData(romData), .ramAddr(ramAddr),
         .ramRdData(ramRdData), .ramWrEn(ramWrEn), .ramWrData(ramWrData));
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            end_of_test();
        end
    end
    task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // entered in a fetch cycle; the word goes in just before the rom samples it
    task automatic runOp(input logic [7:0] op);
        logic [5:0] a;
        logic [3:0] m, wd;
        logic wr, tk;
        a = {eX, eY};
        m = eRam[a];
        wr = 1'b0;
        wd = eAcc;
        tk = (op[7:6] == 2'h3) && eFlag;
        u_nibble_core_rom_ram.rom[{eCb, ePc}] = op;
        if (op < 8'h08 || op[7:4] inside {4'h1, 4'h4, 4'h5, 4'h6} || op[7:6] == 2'h3)
            eFlag = 1'b1;
        casez (op)
            8'h00: eAcc = eY;
            8'h01: eY = eAcc;
            8'h02: eAcc = 4'h0;
            8'h03: wr = 1'b1;
            8'h04: {wr, eY} = {1'b1, eY + 4'h1};
            8'h05: eY = m;
            8'h06: eAcc = m;
            8'h07: {wr, eAcc} = {1'b1, m};
            8'b0001_00??: eX = op[1:0];
            8'b0001_01??: {wr, wd} = {1'b1, m | (4'h1 << op[1:0])};
            8'b0001_10??: {wr, wd} = {1'b1, m & ~(4'h1 << op[1:0])};
            8'b0001_11??: eFlag = m[op[1:0]];
            8'b0100_????: eY = op[3:0];
            8'b0101_????: {wr, wd, eY} = {1'b1, op[3:0], eY + 4'h1};
            8'b0110_????: ePend = op[3:0];
            default: ;
        endcase
        if (tk)
            {eCb, ePc} = {ePend, op[5:0]};
        else
            ePc = {ePc[4:0], ~(ePc[5] ^ ePc[4])};
        if (wr)
            eRam[a] = wd;
        repeat (3) @(negedge clk);
        check("retire", 10'(1'b1), 10'(retire));
        check("accumulator", 10'(eAcc), 10'(accumulator));
        check("indexY", 10'(eY), 10'(indexY));
        check("bankX", 10'(eX), 10'(bankX));
        check("conditionFlag", 10'(eFlag), 10'(conditionFlag));
        check("romAddr", {eCb, ePc}, romAddr);
        check("pendingCodeBank", 10'(ePend), 10'(pendingCodeBank));
        check("currentCodeBank", 10'(eCb), 10'(currentCodeBank));
        check("ramWrEn", 10'(wr), 10'(ramWrEn));
        check("ramAddr", 10'(a), 10'(ramAddr));
        if (wr)
            check("ramWrData", 10'(wd), 10'(ramWrData));
    endtask
    task automatic regMoves();
        runOp(8'h4a);
        runOp(8'h00);
        runOp(8'h02);
        runOp(8'h01);
    endtask
    task automatic ramMoves();
        for (int n = 0; n < 4; n++)
            runOp(8'h10 | n[7:0]);
        runOp(8'h4f);
        runOp(8'h5c);
        runOp(8'h4f);
        runOp(8'h06);
        runOp(8'h04);
        runOp(8'h07);
        runOp(8'h03);
        runOp(8'h05);
    endtask
    task automatic bitOps();
        for (int n = 0; n < 4; n++)
        begin
            runOp(8'h14 | n[7:0]);
            runOp(8'h1c | n[7:0]);
            runOp(8'h18 | n[7:0]);
            runOp(8'h1c | n[7:0]);
        end
    endtask
    // entered with the flag low from the last bit test
    task automatic jumps();
        runOp(8'h08);
        runOp(8'hc5);
        runOp(8'h63);
        runOp(8'hea);
        runOp(8'hc0);
        runOp(8'h60);
        runOp(8'hfe);
    endtask
    initial
    begin
        for (int i = 0; i < 64; i++)
            eRam[i] = i[3:0] ^ 4'h5;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        regMoves();
        ramMoves();
        bitOps();
        jumps();
        end_of_test();
    end
endmodule
`default_nettype wire
